//--- core/sfpi_pkg.sv
// Purpose: Constants and types for the set-flag and set-port instruction block
// Assumes: 10-bit instruction words, 4-bit Y index, APB register access
// Notes:   Opcode for the port C set word is a chosen encoding
// How it works
// - Bank set opcode, one word, carry untouched
// - Next table reference forces page bit six
// - Bank flag selects table pages 64 to 127
// - Carry set opcode writes carry, no skip
// - Port D bit set picks bit by Y
package sfpi_pkg;
  localparam int          INSTR_W        = 10;
  localparam int          Y_W            = 4;
  localparam int          PORTD_W        = 5;
  localparam int          PAGE_W         = 7;
  localparam logic [9:0]  OP_SET_BANK    = 10'h041;
  localparam logic [9:0]  OP_SET_CARRY   = 10'h007;
  localparam logic [9:0]  OP_SET_PORT_C  = 10'h28d;
  localparam logic [9:0]  OP_SET_PORT_D  = 10'h015;
  localparam logic [3:0]  Y_MAX          = 4'h4;
  localparam logic [11:0] ADDR_STATUS    = 12'h000;
  localparam logic [11:0] ADDR_CTRL      = 12'h004;
  localparam logic [11:0] ADDR_COUNT     = 12'h008;
  localparam int          ST_CARRY_BIT   = 0;
  localparam int          ST_BANK_BIT    = 1;
  localparam int          ST_PORTC_BIT   = 2;
  localparam int          ST_PORTD_LSB   = 4;
  localparam int          CTRL_EN_BIT    = 0;
  localparam logic        CTRL_EN_RST    = 1'b1;
  localparam logic [15:0] COUNT_RST      = 16'h0000;

  typedef enum logic [2:0] {
    SFPI_OP_NONE,
    SFPI_OP_BANK,
    SFPI_OP_CARRY,
    SFPI_OP_PORTC,
    SFPI_OP_PORTD
  } sfpi_op_t;

  typedef struct packed {
    logic               carry;
    logic               bank;
    logic               port_c;
    logic [PORTD_W-1:0] port_d;
  } sfpi_flags_t;
endpackage : sfpi_pkg

//--- core/sfpi_portd_dec.sv
// Purpose: Turns the Y index into a one-hot port D bit mask
// Assumes: Y comes from the core register file on the same clock
// Notes:   Out-of-range Y gives an all-zero mask
`timescale 1ns/1ps
module sfpi_portd_dec #(
  parameter int NBITS = 5
) (
  // Index
  input  wire logic [3:0]       y_idx,
  // Mask
  output logic      [NBITS-1:0] bit_mask,
  output logic                  y_in_range
);
  initial begin
    if (NBITS < 1 || NBITS > 16) begin
      $error("sfpi_portd_dec: NBITS out of range");
    end
  end

  assign y_in_range = (y_idx < 4'(NBITS));

  genvar gi;
  generate
    for (gi = 0; gi < NBITS; gi++) begin : g_bit
      assign bit_mask[gi] = (y_idx == 4'(gi));
    end
  endgenerate
endmodule : sfpi_portd_dec

//--- core/sfpi_top.sv
// Purpose: Executes the bank, carry, port C and port D bit set instructions
// Assumes: instr_valid pulses once per executed instruction cycle
// Notes:   Status and enable are reachable over APB
`timescale 1ns/1ps
module sfpi_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Instruction path
  input  wire logic        instr_valid,
  input  wire logic [9:0]  instr_word,
  input  wire logic [3:0]  y_reg,
  // Table reference path
  input  wire logic        table_reference_instr,
  input  wire logic [5:0]  table_page_low,
  output logic      [6:0]  table_page,
  // Carry updates from other instructions
  input  wire logic        carry_wr_en,
  input  wire logic        carry_wr_val,
  // Port clear from other instructions
  input  wire logic        port_c_clr,
  input  wire logic [4:0]  port_d_clr,
  // Flag and port state
  output logic             carry_flag,
  output logic             port_c,
  output logic      [4:0]  port_d,
  output logic             skip_next,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  sfpi_pkg::sfpi_flags_t flags_ff, nxt_flags;
  sfpi_pkg::sfpi_op_t    op;
  logic                  ctrl_en_ff, nxt_ctrl_en;
  logic [15:0]           count_ff, nxt_count;
  logic [31:0]           prdata_ff, nxt_prdata;
  logic                  pslverr_ff, nxt_pslverr;
  logic [4:0]            d_mask;
  logic                  y_ok;
  logic                  apb_acc;

  sfpi_portd_dec #(
    .NBITS (sfpi_pkg::PORTD_W)
  ) u_dec (
    .y_idx      (y_reg),
    .bit_mask   (d_mask),
    .y_in_range (y_ok)
  );

  // Instruction decode
  always_comb begin
    op = sfpi_pkg::SFPI_OP_NONE;
    if (instr_valid && ctrl_en_ff) begin
      case (instr_word)
        sfpi_pkg::OP_SET_BANK:   op = sfpi_pkg::SFPI_OP_BANK;
        sfpi_pkg::OP_SET_CARRY:  op = sfpi_pkg::SFPI_OP_CARRY;
        sfpi_pkg::OP_SET_PORT_C: op = sfpi_pkg::SFPI_OP_PORTC;
        sfpi_pkg::OP_SET_PORT_D: op = sfpi_pkg::SFPI_OP_PORTD;
        default:                 op = sfpi_pkg::SFPI_OP_NONE;
      endcase
    end
  end

  // Flag and port next state
  always_comb begin
    nxt_flags = flags_ff;
    if (carry_wr_en) begin
      nxt_flags.carry = carry_wr_val;
    end
    if (port_c_clr) begin
      nxt_flags.port_c = 1'b0;
    end
    nxt_flags.port_d = flags_ff.port_d & ~port_d_clr;
    // Bank flag is spent by the table reference that uses it
    if (table_reference_instr) begin
      nxt_flags.bank = 1'b0;
    end
    case (op)
      sfpi_pkg::SFPI_OP_BANK:  nxt_flags.bank = 1'b1;
      sfpi_pkg::SFPI_OP_CARRY: nxt_flags.carry = 1'b1;
      sfpi_pkg::SFPI_OP_PORTC: nxt_flags.port_c = 1'b1;
      sfpi_pkg::SFPI_OP_PORTD: begin
        if (y_ok) begin
          nxt_flags.port_d = nxt_flags.port_d | d_mask;
        end
      end
      default: nxt_flags = nxt_flags;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Upper page range when bank flag is set
  assign table_page = {flags_ff.bank, table_page_low};
  assign carry_flag = flags_ff.carry;
  assign port_c     = flags_ff.port_c;
  assign port_d     = flags_ff.port_d;
  assign skip_next  = 1'b0;

  // APB slave, zero wait states
  assign apb_acc = psel && penable;
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  always_comb begin
    nxt_ctrl_en = ctrl_en_ff;
    nxt_count   = count_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (op != sfpi_pkg::SFPI_OP_NONE) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (psel && !penable) begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
        sfpi_pkg::ADDR_STATUS: begin
          nxt_prdata[sfpi_pkg::ST_CARRY_BIT] = flags_ff.carry;
          nxt_prdata[sfpi_pkg::ST_BANK_BIT]  = flags_ff.bank;
          nxt_prdata[sfpi_pkg::ST_PORTC_BIT] = flags_ff.port_c;
          nxt_prdata[sfpi_pkg::ST_PORTD_LSB +: sfpi_pkg::PORTD_W] = flags_ff.port_d;
        end
        sfpi_pkg::ADDR_CTRL:  nxt_prdata[sfpi_pkg::CTRL_EN_BIT] = ctrl_en_ff;
        sfpi_pkg::ADDR_COUNT: nxt_prdata[15:0] = count_ff;
        default:              nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (apb_acc) begin
      case (paddr)
        sfpi_pkg::ADDR_STATUS: nxt_pslverr = pwrite;
        sfpi_pkg::ADDR_CTRL: begin
          if (pwrite) begin
            nxt_ctrl_en = pwdata[sfpi_pkg::CTRL_EN_BIT];
          end
        end
        sfpi_pkg::ADDR_COUNT: begin
          if (pwrite) begin
            nxt_count = sfpi_pkg::COUNT_RST;
          end
        end
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_ff <= sfpi_pkg::CTRL_EN_RST;
      count_ff   <= sfpi_pkg::COUNT_RST;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_en_ff <= nxt_ctrl_en;
      count_ff   <= nxt_count;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // pslverr is registered, so it shows in the cycle after the access edge
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence bank_set_s;
    instr_valid && ctrl_en_ff && instr_word == sfpi_pkg::OP_SET_BANK && !table_reference_instr;
  endsequence

  sequence tref_use_s;
    table_reference_instr;
  endsequence

  bank_set_a: assert property (bank_set_s |=> flags_ff.bank)
    else $error("bank flag not set by bank set word");

  bank_carry_a: assert property ((bank_set_s and !carry_wr_en) |=> $stable(flags_ff.carry))
    else $error("bank set word changed carry");

  tref_upper_a: assert property (flags_ff.bank ##0 tref_use_s |-> table_page[6] ##1 !flags_ff.bank)
    else $error("table page bit six not forced or flag not spent");

  page_range_a: assert property (tref_use_s |-> (table_page >= 7'd64) == flags_ff.bank)
    else $error("table page range does not follow bank flag");

  carry_set_a: assert property (instr_valid && ctrl_en_ff && instr_word == sfpi_pkg::OP_SET_CARRY
                                |=> carry_flag && !skip_next)
    else $error("carry set word failed");

  portc_set_a: assert property (instr_valid && ctrl_en_ff && instr_word == sfpi_pkg::OP_SET_PORT_C
                                && !carry_wr_en |=> port_c && $stable(carry_flag))
    else $error("port C set word failed");

  portd_set_a: assert property (instr_valid && ctrl_en_ff && instr_word == sfpi_pkg::OP_SET_PORT_D
                                && y_reg <= sfpi_pkg::Y_MAX && port_d_clr == 5'h00
                                |=> port_d[$past(y_reg[2:0])] && (port_d | ($past(port_d) | 5'(1 << $past(y_reg))))
                                == ($past(port_d) | 5'(1 << $past(y_reg))))
    else $error("port D bit set wrong");

  portd_hold_a: assert property (instr_valid && instr_word == sfpi_pkg::OP_SET_PORT_D
                                 && y_reg > sfpi_pkg::Y_MAX && port_d_clr == 5'h00
                                 |=> $stable(port_d))
    else $error("port D changed with Y out of range");
endmodule : sfpi_top

//--- sim/test_set_flag_port_instructions.sv
// Purpose: Self-checking bench for the set flag and set port instruction block
// Assumes: pready may be constant high, pslverr lands one cycle after the access edge
// Notes:   Inputs change by non-blocking assignment at rising edges, outputs sampled 1 ns later except prdata, which apb takes at the edge
`timescale 1ns/1ps
module test_set_flag_port_instructions;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        instr_valid = 1'b0;
  logic [9:0]  instr_word = 10'h000;
  logic [3:0]  y_reg = 4'h0;
  logic        table_reference_instr = 1'b0;
  logic [5:0]  table_page_low = 6'h3f;
  logic [6:0]  table_page;
  logic        carry_wr_en = 1'b0;
  logic        carry_wr_val = 1'b0;
  logic        port_c_clr = 1'b0;
  logic [4:0]  port_d_clr = 5'h00;
  logic        carry_flag;
  logic        port_c;
  logic [4:0]  port_d;
  logic        skip_next;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_tests = 0;

  always #20 clk = ~clk;

  sfpi_top i_dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word), .y_reg(y_reg),
    .table_reference_instr(table_reference_instr), .table_page_low(table_page_low), .table_page(table_page),
    .carry_wr_en(carry_wr_en), .carry_wr_val(carry_wr_val), .port_c_clr(port_c_clr), .port_d_clr(port_d_clr),
    .carry_flag(carry_flag), .port_c(port_c), .port_d(port_d), .skip_next(skip_next), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One instruction word, outputs sampled after the executing edge
  task automatic exec(input logic [9:0] op, input logic [3:0] y);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= op;
    y_reg       <= y;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : exec

  // Clears carry and both ports through the side inputs
  task automatic clr_all;
    @(posedge clk);
    carry_wr_en <= 1'b1;
    port_c_clr  <= 1'b1;
    port_d_clr  <= 5'h1f;
    @(posedge clk);
    carry_wr_en <= 1'b0;
    port_c_clr  <= 1'b0;
    port_d_clr  <= 5'h00;
    #1;
  endtask : clr_all

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("carry after reset", carry_flag, 0);
    check("page after reset", table_page, 32'h3f);
    exec(sfpi_pkg::OP_SET_CARRY, 4'h0);
    check("carry set", carry_flag, 1);
    check("no skip", skip_next, 0);
    clr_all();
    exec(sfpi_pkg::OP_SET_BANK, 4'h0);
    check("carry kept by bank set", carry_flag, 0);
    check("upper page top", table_page, 32'h7f);
    @(posedge clk);
    table_page_low <= 6'h00;
    #1;
    check("upper page bottom", table_page, 32'h40);
    @(posedge clk);
    table_reference_instr <= 1'b1;
    #1;
    check("page bit six forced", table_page, 32'h40);
    @(posedge clk);
    table_reference_instr <= 1'b0;
    #1;
    check("bank spent", table_page, 32'h00);
    exec(sfpi_pkg::OP_SET_PORT_C, 4'h0);
    check("port c set", port_c, 1);
    check("carry kept by port c", carry_flag, 0);
    for (int y = 0; y < 5; y++) begin
      clr_all();
      exec(sfpi_pkg::OP_SET_PORT_D, 4'(y));
      check("port d bit", port_d, 32'h1 << y);
    end
    for (int y = 5; y < 16; y++) begin
      exec(sfpi_pkg::OP_SET_PORT_D, 4'(y));
      check("port d out of range", port_d, 32'h10);
    end
    apb(1'b0, sfpi_pkg::ADDR_STATUS, 32'h0, rd);
    check("status", rd, 32'h100);
    apb(1'b0, sfpi_pkg::ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", rd, 32'h1);
    apb(1'b1, sfpi_pkg::ADDR_COUNT, 32'h0, rd);
    exec(sfpi_pkg::OP_SET_CARRY, 4'h0);
    exec(sfpi_pkg::OP_SET_PORT_C, 4'h0);
    exec(sfpi_pkg::OP_SET_BANK, 4'h0);
    apb(1'b0, sfpi_pkg::ADDR_COUNT, 32'h0, rd);
    check("count", rd, 32'h3);
    apb(1'b1, sfpi_pkg::ADDR_CTRL, 32'h0, rd);
    clr_all();
    exec(sfpi_pkg::OP_SET_CARRY, 4'h0);
    check("carry while disabled", carry_flag, 0);
    apb(1'b1, sfpi_pkg::ADDR_CTRL, 32'h1, rd);
    apb(1'b0, 12'h00c, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    apb(1'b1, sfpi_pkg::ADDR_STATUS, 32'h5, rd);
    #1;
    check("status write error", pslverr, 1);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : test_set_flag_port_instructions
